// ===== rtl/vfc_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the V/f curve control block.
// Assumes: Frequencies in 0.1 Hz steps, voltages in 0.1 % steps, filter times in ms.
// Notes: Included by the design file and by the bench.
// Operation
// - Selector 0 gives scalar V/f, 5 gives sensorless vector; 1 to 4, 6 and 7 ignored.
// - Selecting vector mode from the panel raises the guided setup menu flag.
// - Total and active current filtered, 0..9999 ms, default 50; settles after three constants.
// - Vector-mode slip compensation filtered, default 500 ms; settles after three constants.
// - Compensation option word, one feature per bit, reset value 000Bh.
// - Option bit 0 clear removes slip compensation during regeneration.
// - Dead time compensation corrects output pulse width distortion while enabled.
// - Option bit 1 clear disables dead time compensation and pulse feedback fault.
// - Option bit 2 set enables closed-loop current damping against resonance.
// - Option bit 3 chooses the action on switch overtemperature alarm.
// - Speed reference clamped between minimum and maximum frequency before the curve.
// - Curve has five points: boost at 0 Hz, three pairs, 100 % at max.
// - Between field weakening point and maximum the voltage stays at 100 %.
// - Default points 1 to 3 coincide at rated frequency, giving a straight line.
// - Misordered frequencies or slope over 10 %/Hz raise config error status.
// - Below 0.1 Hz output pulses are cut unless DC braking is active.
// - After reset the control mode is scalar V/f.
// - Curve voltages range 0.0 to 100.0 %.
// - Curve frequencies range 0.0 to 500.0 Hz.
// - Manual boost 0.0 to 30.0 %, acting only from zero to low frequency.
`ifndef VFC_DEFINES_SVH
`define VFC_DEFINES_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define VFC_OFS_CTRL 8'h00
`define VFC_OFS_CURF 8'h04
`define VFC_OFS_SLIPF 8'h08
`define VFC_OFS_OPT 8'h0C
`define VFC_OFS_FMIN 8'h10
`define VFC_OFS_FMAX 8'h14
`define VFC_OFS_BOOST 8'h18
`define VFC_OFS_VMAX 8'h1C
`define VFC_OFS_VMID 8'h20
`define VFC_OFS_VLOW 8'h24
`define VFC_OFS_FFW 8'h28
`define VFC_OFS_FMID 8'h2C
`define VFC_OFS_FLOW 8'h30
`define VFC_OFS_SREF 8'h34
`define VFC_OFS_STAT 8'h38
`define VFC_OFS_OUTF 8'h3C
`define VFC_OFS_OUTV 8'h40
// ****************************************************************
// Fields and codes
// ****************************************************************
`define VFC_SEL_SCALAR 3'h0
`define VFC_SEL_VECTOR 3'h5
`define VFC_CTRL_PANEL_BIT 7
`define VFC_OPT_REGEN_SLIP 0
`define VFC_OPT_DEADTIME 1
`define VFC_OPT_STAB 2
`define VFC_OPT_OT_REDUCE 3
`define VFC_STAT_CFG_ERR 0
`define VFC_STAT_VECTOR 1
`define VFC_STAT_SETUP 2
`define VFC_STAT_PWM 3
`define VFC_STAT_CUR_OK 4
`define VFC_STAT_SLIP_OK 5
// ****************************************************************
// Reset values and ranges
// ****************************************************************
`define VFC_RST_OPT 16'h000B
`define VFC_RST_CURF 16'h0032
`define VFC_RST_SLIPF 16'h01F4
`define VFC_RST_FMIN 16'h0000
`define VFC_RST_FMAX 16'h0294
`define VFC_RST_BOOST 16'h000A
`define VFC_RATED_60 16'h0258
`define VFC_RATED_50 16'h01F4
`define VFC_V_FULL 16'h03E8
`define VFC_F_MAX_RANGE 16'h1388
`define VFC_BOOST_MAX 16'h012C
`define VFC_TAU_MAX 16'h270F
`define VFC_SLOPE_MAX 16'h000A
`define VFC_SETTLE_MULT 16'h0003
`define VFC_F_PULSE_MIN 16'h0001
// ****************************************************************
// Timing
// ****************************************************************
`define VFC_CLK_MHZ 100
`define VFC_TICK_US 1000
`define VFC_TICK_CYCLES (`VFC_TICK_US * `VFC_CLK_MHZ)
`endif

// ===== rtl/vfc_pkg.sv
// Purpose: Types shared by the V/f curve control block and its bench.
// Assumes: Classic Wishbone with an 8-bit byte address and 32-bit data.
// Notes: Numbers live in vfc_defines.svh.
package vfc_pkg;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} vfc_wb_req_t;
	typedef struct packed {
		logic [15:0] freq;
		logic [15:0] volt;
		logic pwm_en;
	} vfc_drive_t;
	typedef enum logic {VFC_SCALAR, VFC_VECTOR} vfc_mode_t;
endpackage : vfc_pkg

// ===== rtl/vfc_top.sv
// Purpose: V/f curve generator, control mode selection, filters and compensation options.
// Assumes: All inputs synchronous to clk_i; current and slip samples signed 16 bit.
// Notes: Registers on classic Wishbone; ack one cycle after the strobe is seen.
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vfc_defines.svh"
module vfc_top #(
	parameter int TICK_CYCLES = `VFC_TICK_CYCLES,
	parameter bit RATED_50HZ = 1'b0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire vfc_pkg::vfc_wb_req_t wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Measurements and power stage status
	input wire logic signed [15:0] cur_total_i,
	input wire logic signed [15:0] cur_active_i,
	input wire logic signed [15:0] slip_i,
	input wire logic regen_i,
	input wire logic dc_brake_i,
	input wire logic [15:0] pulse_cmd_i,
	input wire logic [15:0] pulse_meas_i,
	input wire logic pulse_fb_fault_raw_i,
	input wire logic switch_overtemp_alarm_i,
	// Drive outputs
	output vfc_pkg::vfc_drive_t drive_o,
	output logic signed [15:0] cur_total_flt_o,
	output logic signed [15:0] cur_active_flt_o,
	output logic signed [15:0] slip_comp_o,
	output logic signed [15:0] deadtime_corr_o,
	output logic signed [15:0] stab_corr_o,
	output logic pulse_feedback_fault_o,
	output logic ot_reduce_o,
	output logic ot_trip_o,
	output logic sensorless_vector_mode_o,
	output logic guided_setup_menu_o,
	output logic config_error_status_o
);
	import vfc_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [15:0] sat(input logic [15:0] v, input logic [15:0] lim);
		sat = (v > lim) ? lim : v;
	endfunction : sat

	// Integer step: a difference smaller than the time constant does not move the output.
	function automatic logic signed [15:0] lpf(input logic signed [15:0] y, input logic signed [15:0] x,
			input logic [15:0] tau);
		logic signed [16:0] d;
		logic signed [16:0] s;
		d = 17'(x) - 17'(y);
		s = (tau == 16'h0000) ? d : d / $signed({1'b0, tau});
		lpf = 16'(17'(y) + s);
	endfunction : lpf

	function automatic logic [15:0] interp(input logic [15:0] f, input logic [15:0] f0, input logic [15:0] v0,
			input logic [15:0] f1, input logic [15:0] v1);
		logic signed [33:0] num;
		logic signed [16:0] dv;
		dv = $signed({1'b0, v1}) - $signed({1'b0, v0});
		num = 34'(dv) * $signed({2'b00, f - f0});
		if (f1 <= f0) begin
			interp = v1;
		end else begin
			interp = 16'($signed({18'h00000, v0}) + num / $signed({18'h00000, f1 - f0}));
		end
	endfunction : interp

	// Voltage in 0.1 % and frequency in 0.1 Hz make the %/Hz slope dv/df directly.
	function automatic logic steep(input logic [15:0] f0, input logic [15:0] v0,
			input logic [15:0] f1, input logic [15:0] v1);
		logic [15:0] dv;
		dv = (v1 > v0) ? v1 - v0 : v0 - v1;
		steep = (f1 > f0) ? (20'(dv) > 20'(f1 - f0) * 20'(`VFC_SLOPE_MAX)) : 1'b0;
	endfunction : steep

	// The ack gate in the strobe blocks a write in the ack cycle only; a request held longer writes again the cycle after.
	function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] ofs);
		wr_hit = w && (a == ofs);
	endfunction : wr_hit

	function automatic logic is_vec(input vfc_mode_t m);
		is_vec = (m == VFC_VECTOR);
	endfunction : is_vec

	// Three time constants, after which a filter counts as settled.
	function automatic logic [15:0] settle_of(input logic [15:0] tau);
		settle_of = 16'(sat(tau, `VFC_TAU_MAX) * `VFC_SETTLE_MULT);
	endfunction : settle_of

	// ****************************************************************
	// Registers
	// ****************************************************************
	localparam logic [15:0] RATED_F = RATED_50HZ ? `VFC_RATED_50 : `VFC_RATED_60;
	vfc_mode_t mode_reg;
	logic setup_reg;
	logic [15:0] curf_reg, slipf_reg, opt_reg, fmin_reg, fmax_reg, boost_reg;
	logic [15:0] vmax_reg, vmid_reg, vlow_reg, ffw_reg, fmid_reg, flow_reg, sref_reg;
	logic [15:0] wdat;
	logic req, wr;
	assign req = wb_req_i.cyc & wb_req_i.stb;
	assign wr = req & wb_req_i.we & ~wb_ack_o;
	always_comb begin
		wdat[7:0] = wb_req_i.sel[0] ? wb_req_i.dat[7:0] : 8'h00;
		wdat[15:8] = wb_req_i.sel[1] ? wb_req_i.dat[15:8] : 8'h00;
	end

	// Codes without a function leave the mode as it was instead of falling back to scalar.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_reg <= VFC_SCALAR;
		end else if (wr_hit(wr, wb_req_i.adr, `VFC_OFS_CTRL) && wb_req_i.sel[0]) begin
			if (wdat[2:0] == `VFC_SEL_SCALAR) begin
				mode_reg <= VFC_SCALAR;
			end else if (wdat[2:0] == `VFC_SEL_VECTOR) begin
				mode_reg <= VFC_VECTOR;
			end
		end
	end

	// The panel bit tags a write made from the keypad; network writes leave the menu alone.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			setup_reg <= 1'b0;
		end else if (wr_hit(wr, wb_req_i.adr, `VFC_OFS_CTRL) && wb_req_i.sel[0] && wdat[2:0] == `VFC_SEL_VECTOR
				&& wdat[`VFC_CTRL_PANEL_BIT]) begin
			setup_reg <= 1'b1;
		end else if (wr_hit(wr, wb_req_i.adr, `VFC_OFS_STAT) && wdat[`VFC_STAT_SETUP]) begin
			setup_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			curf_reg <= `VFC_RST_CURF;
			slipf_reg <= `VFC_RST_SLIPF;
			opt_reg <= `VFC_RST_OPT;
			fmin_reg <= `VFC_RST_FMIN;
			fmax_reg <= `VFC_RST_FMAX;
			boost_reg <= `VFC_RST_BOOST;
			vmax_reg <= `VFC_V_FULL;
			vmid_reg <= `VFC_V_FULL;
			vlow_reg <= `VFC_V_FULL;
			ffw_reg <= RATED_F;
			fmid_reg <= RATED_F;
			flow_reg <= RATED_F;
			sref_reg <= 16'h0000;
		end else if (wr) begin
			case (wb_req_i.adr)
				`VFC_OFS_CURF: curf_reg <= sat(wdat, `VFC_TAU_MAX);
				`VFC_OFS_SLIPF: slipf_reg <= sat(wdat, `VFC_TAU_MAX);
				`VFC_OFS_OPT: opt_reg <= wdat;
				`VFC_OFS_FMIN: fmin_reg <= sat(wdat, `VFC_F_MAX_RANGE);
				`VFC_OFS_FMAX: fmax_reg <= sat(wdat, `VFC_F_MAX_RANGE);
				`VFC_OFS_BOOST: boost_reg <= sat(wdat, `VFC_BOOST_MAX);
				`VFC_OFS_VMAX: vmax_reg <= sat(wdat, `VFC_V_FULL);
				`VFC_OFS_VMID: vmid_reg <= sat(wdat, `VFC_V_FULL);
				`VFC_OFS_VLOW: vlow_reg <= sat(wdat, `VFC_V_FULL);
				`VFC_OFS_FFW: ffw_reg <= sat(wdat, `VFC_F_MAX_RANGE);
				`VFC_OFS_FMID: fmid_reg <= sat(wdat, `VFC_F_MAX_RANGE);
				`VFC_OFS_FLOW: flow_reg <= sat(wdat, `VFC_F_MAX_RANGE);
				`VFC_OFS_SREF: sref_reg <= wdat;
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Curve and configuration check
	// ****************************************************************
	logic [15:0] f_ref, v_curve;
	logic cfg_err;
	always_comb begin
		f_ref = sref_reg;
		if (f_ref > fmax_reg) begin
			f_ref = fmax_reg;
		end
		// The minimum is applied last so that a minimum above the maximum still wins.
		if (f_ref < fmin_reg) begin
			f_ref = fmin_reg;
		end
		if (f_ref < flow_reg) begin
			v_curve = interp(f_ref, 16'h0000, boost_reg, flow_reg, vlow_reg);
		end else if (f_ref < fmid_reg) begin
			v_curve = interp(f_ref, flow_reg, vlow_reg, fmid_reg, vmid_reg);
		end else if (f_ref < ffw_reg) begin
			v_curve = interp(f_ref, fmid_reg, vmid_reg, ffw_reg, vmax_reg);
		end else begin
			v_curve = `VFC_V_FULL;
		end
	end

	// Three coinciding points are the factory straight line and are not flagged as misordered.
	always_comb begin
		cfg_err = steep(16'h0000, boost_reg, flow_reg, vlow_reg) | steep(flow_reg, vlow_reg, fmid_reg, vmid_reg)
			| steep(fmid_reg, vmid_reg, ffw_reg, vmax_reg) | steep(ffw_reg, vmax_reg, fmax_reg, `VFC_V_FULL);
		if (!(flow_reg == fmid_reg && fmid_reg == ffw_reg)) begin
			cfg_err = cfg_err | (flow_reg >= fmid_reg) | (fmid_reg >= ffw_reg);
		end
	end

	// Drive and status follow a register write one cycle later.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drive_o <= '0;
			config_error_status_o <= 1'b0;
			sensorless_vector_mode_o <= 1'b0;
			guided_setup_menu_o <= 1'b0;
		end else begin
			drive_o.freq <= f_ref;
			drive_o.volt <= v_curve;
			drive_o.pwm_en <= (f_ref >= `VFC_F_PULSE_MIN) | dc_brake_i;
			config_error_status_o <= cfg_err;
			sensorless_vector_mode_o <= is_vec(mode_reg);
			guided_setup_menu_o <= setup_reg;
		end
	end

	// ****************************************************************
	// Filters on a millisecond tick
	// ****************************************************************
	logic [31:0] tick_cnt;
	logic tick;
	logic [15:0] cur_settle, slip_settle;
	logic signed [15:0] slip_src;
	// One tick per millisecond; a shorter tick in simulation keeps filter runs brief.
	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));
	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			tick_cnt <= 32'h00000000;
		end else begin
			tick_cnt <= tick_cnt + 32'h00000001;
		end
	end

	// Slip is dropped during regeneration unless option bit 0 keeps it.
	assign slip_src = (is_vec(mode_reg) && !(regen_i && !opt_reg[`VFC_OPT_REGEN_SLIP])) ? slip_i : 16'sh0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_total_flt_o <= 16'sh0000;
			cur_active_flt_o <= 16'sh0000;
		end else if (tick) begin
			cur_total_flt_o <= lpf(cur_total_flt_o, cur_total_i, curf_reg);
			cur_active_flt_o <= lpf(cur_active_flt_o, cur_active_i, curf_reg);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slip_comp_o <= 16'sh0000;
		end else if (tick) begin
			slip_comp_o <= lpf(slip_comp_o, slip_src, slipf_reg);
		end
	end

	// Settle timers count three time constants after a new constant is written.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_settle <= settle_of(`VFC_RST_CURF);
		end else if (wr_hit(wr, wb_req_i.adr, `VFC_OFS_CURF)) begin
			cur_settle <= settle_of(wdat);
		end else if (tick && cur_settle != 16'h0000) begin
			cur_settle <= cur_settle - 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slip_settle <= settle_of(`VFC_RST_SLIPF);
		end else if (wr_hit(wr, wb_req_i.adr, `VFC_OFS_SLIPF)) begin
			slip_settle <= settle_of(wdat);
		end else if (tick && slip_settle != 16'h0000) begin
			slip_settle <= slip_settle - 16'h0001;
		end
	end

	// ****************************************************************
	// Compensation options
	// ****************************************************************
	// Dead time term and feedback fault share option bit 1, so both go off together.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			deadtime_corr_o <= 16'sh0000;
			stab_corr_o <= 16'sh0000;
			pulse_feedback_fault_o <= 1'b0;
			ot_reduce_o <= 1'b0;
			ot_trip_o <= 1'b0;
		end else begin
			deadtime_corr_o <= opt_reg[`VFC_OPT_DEADTIME] ? 16'(pulse_cmd_i - pulse_meas_i) : 16'sh0000;
			pulse_feedback_fault_o <= opt_reg[`VFC_OPT_DEADTIME] & pulse_fb_fault_raw_i;
			stab_corr_o <= opt_reg[`VFC_OPT_STAB] ? 16'((17'(cur_total_flt_o) - 17'(cur_total_i)) >>> 2) : 16'sh0000;
			ot_reduce_o <= switch_overtemp_alarm_i & opt_reg[`VFC_OPT_OT_REDUCE];
			ot_trip_o <= switch_overtemp_alarm_i & ~opt_reg[`VFC_OPT_OT_REDUCE];
		end
	end

	// ****************************************************************
	// Bus read path
	// ****************************************************************
	// Unmapped offsets read as zero and are still acknowledged, so a stray access cannot hang the bus.
	logic [15:0] rdat;
	always_comb begin
		case (wb_req_i.adr)
			`VFC_OFS_CTRL: rdat = is_vec(mode_reg) ? 16'(`VFC_SEL_VECTOR) : 16'(`VFC_SEL_SCALAR);
			`VFC_OFS_CURF: rdat = curf_reg;
			`VFC_OFS_SLIPF: rdat = slipf_reg;
			`VFC_OFS_OPT: rdat = opt_reg;
			`VFC_OFS_FMIN: rdat = fmin_reg;
			`VFC_OFS_FMAX: rdat = fmax_reg;
			`VFC_OFS_BOOST: rdat = boost_reg;
			`VFC_OFS_VMAX: rdat = vmax_reg;
			`VFC_OFS_VMID: rdat = vmid_reg;
			`VFC_OFS_VLOW: rdat = vlow_reg;
			`VFC_OFS_FFW: rdat = ffw_reg;
			`VFC_OFS_FMID: rdat = fmid_reg;
			`VFC_OFS_FLOW: rdat = flow_reg;
			`VFC_OFS_SREF: rdat = sref_reg;
			`VFC_OFS_STAT: rdat = {10'h000, slip_settle == 16'h0000, cur_settle == 16'h0000, drive_o.pwm_en,
				setup_reg, is_vec(mode_reg), config_error_status_o};
			`VFC_OFS_OUTF: rdat = drive_o.freq;
			`VFC_OFS_OUTV: rdat = drive_o.volt;
			default: rdat = 16'h0000;
		endcase
	end

	// A strobe is answered in the next cycle and the ack drops after one cycle, so a master
	// that keeps its request up past the ack is answered and written again every second cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			wb_dat_o <= (req & ~wb_ack_o & ~wb_req_i.we) ? {16'h0000, rdat} : 32'h00000000;
		end
	end
endmodule : vfc_top
`default_nettype wire

// ===== verification/tb_top.sv
// Purpose: Register-level tests of the V/f curve control block.
// Assumes: Filter tick shortened to TICK cycles.
// Notes: Expected curve values are worked out by hand from the programmed points.
`timescale 1ns/1ps
`default_nettype none
`include "vfc_defines.svh"
module tb_top;
	import vfc_pkg::*;
	localparam int TICK = 10;
	localparam logic signed [15:0] LOAD = 16'sh0120;
	localparam logic [7:0] SAT_ADR [4] = '{`VFC_OFS_VMAX, `VFC_OFS_FFW, `VFC_OFS_BOOST, `VFC_OFS_CURF};
	localparam logic [31:0] SAT_EXP [4] = '{32'h3E8, 32'h1388, 32'h12C, 32'h270F};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	vfc_wb_req_t wb_req_i = '0;
	logic regen_i = 1'b0, dc_brake_i = 1'b0, pulse_fb_fault_raw_i = 1'b0, switch_overtemp_alarm_i = 1'b0;
	logic [15:0] pulse_cmd_i = 16'h0100;
	logic signed [15:0] load = LOAD;
	logic [31:0] wb_dat_o, rdata;
	logic wb_ack_o, pulse_feedback_fault_o, ot_reduce_o, ot_trip_o;
	logic sensorless_vector_mode_o, guided_setup_menu_o, config_error_status_o;
	logic [15:0] pulse_meas_i;
	logic signed [15:0] cur_total_i, cur_active_i, slip_i, cur_total_flt_o, cur_active_flt_o;
	logic signed [15:0] slip_comp_o, deadtime_corr_o, stab_corr_o;
	vfc_drive_t drive_o;
	int error_cnt = 0;
	int num_checks = 0;
	vfc_top #(.TICK_CYCLES(TICK), .RATED_50HZ(1'b0)) vfc_top_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.cur_total_i(cur_total_i), .cur_active_i(cur_active_i), .slip_i(slip_i), .regen_i(regen_i),
		.dc_brake_i(dc_brake_i), .pulse_cmd_i(pulse_cmd_i), .pulse_meas_i(pulse_meas_i),
		.pulse_fb_fault_raw_i(pulse_fb_fault_raw_i), .switch_overtemp_alarm_i(switch_overtemp_alarm_i),
		.drive_o(drive_o), .cur_total_flt_o(cur_total_flt_o), .cur_active_flt_o(cur_active_flt_o),
		.slip_comp_o(slip_comp_o), .deadtime_corr_o(deadtime_corr_o), .stab_corr_o(stab_corr_o),
		.pulse_feedback_fault_o(pulse_feedback_fault_o), .ot_reduce_o(ot_reduce_o), .ot_trip_o(ot_trip_o),
		.sensorless_vector_mode_o(sensorless_vector_mode_o), .guided_setup_menu_o(guided_setup_menu_o),
		.config_error_status_o(config_error_status_o));
	vfc_stage_model vfc_stage_model_inst (.drive_i(drive_o), .load_i(load), .pulse_cmd_i(pulse_cmd_i),
		.cur_total_o(cur_total_i), .cur_active_o(cur_active_i), .slip_o(slip_i), .pulse_meas_o(pulse_meas_i));
	always #5 clk_i = ~clk_i;
	// ****
	// Tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: saw %h expected %h", $time, got, exp);
		end
	endtask : chk
	// The two idle edges after release let registered outputs settle before anyone looks.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_req_i <= {1'b1, 1'b1, we, adr, 4'hF, dat};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rdata = wb_dat_o;
		wb_req_i <= '0;
		if (n >= 50) chk(32'h0, 32'hDEAD);
		repeat (2) @(posedge clk_i);
	endtask : wb
	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		wb(1'b1, adr, dat);
	endtask : wr
	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		chk(rdata, exp);
	endtask : rd
	task automatic tick(input int n);
		repeat (n * TICK + 2) @(posedge clk_i);
	endtask : tick
	task automatic curve(input logic [15:0] sref, input logic [15:0] f, input logic [15:0] v);
		wr(`VFC_OFS_SREF, {16'h0, sref});
		rd(`VFC_OFS_OUTF, {16'h0, f});
		rd(`VFC_OFS_OUTV, {16'h0, v});
	endtask : curve
	task automatic cfg(input logic [7:0] adr, input logic [15:0] val, input logic e);
		wr(adr, {16'h0, val});
		wb(1'b0, `VFC_OFS_STAT, 32'h0);
		chk({rdata[0], config_error_status_o}, {e, e});
	endtask : cfg
	task automatic summarize();
		$display("errors %0d checks %0d", error_cnt, num_checks);
		if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		$display("ERROR %0t: watchdog expired", $time);
		summarize();
	end
	// ****
	// Tests
	// ****
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`VFC_OFS_OPT, 32'h000B);
		rd(`VFC_OFS_CTRL, 32'h0);
		rd(`VFC_OFS_FMID, 32'h258);
		curve(16'h012C, 16'h012C, 16'h01F9);
		curve(16'h02BC, 16'h0294, 16'h03E8);
		curve(16'h0000, 16'h0000, 16'h000A);
		chk(drive_o.pwm_en, 1'b0);
		@(posedge clk_i) dc_brake_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(drive_o.pwm_en, 1'b1);
		@(posedge clk_i) dc_brake_i <= 1'b0;
		wr(`VFC_OFS_FMIN, 32'h32);
		rd(`VFC_OFS_OUTF, 32'h32);
		wr(`VFC_OFS_FMIN, 32'h0);
		cfg(`VFC_OFS_FLOW, 16'h0190, 1'b1);
		cfg(`VFC_OFS_FMID, 16'h01F4, 1'b0);
		cfg(`VFC_OFS_FLOW, 16'h01F4, 1'b1);
		cfg(`VFC_OFS_FLOW, 16'h0032, 1'b1);
		cfg(`VFC_OFS_VLOW, 16'h012C, 1'b0);
		wr(`VFC_OFS_FLOW, 32'hC8);
		wr(`VFC_OFS_FMID, 32'h190);
		cfg(`VFC_OFS_VMID, 16'h0258, 1'b0);
		curve(16'h0064, 16'h0064, 16'h009B);
		curve(16'h012C, 16'h012C, 16'h01C2);
		curve(16'h01F4, 16'h01F4, 16'h0320);
		wr(`VFC_OFS_CTRL, 32'h5);
		chk({sensorless_vector_mode_o, guided_setup_menu_o}, 2'b10);
		for (int v = 1; v < 8; v++) begin
			if (v != 5) wr(`VFC_OFS_CTRL, 32'(v));
			chk(sensorless_vector_mode_o, 1'b1);
		end
		wr(`VFC_OFS_CTRL, 32'h0);
		chk(sensorless_vector_mode_o, 1'b0);
		wr(`VFC_OFS_CTRL, 32'h85);
		rd(`VFC_OFS_STAT, 32'h0E);
		wr(`VFC_OFS_STAT, 32'h4);
		chk(guided_setup_menu_o, 1'b0);
		wr(`VFC_OFS_SLIPF, 32'h0);
		tick(2);
		chk(slip_comp_o, LOAD >>> 3);
		@(posedge clk_i) regen_i <= 1'b1;
		tick(2);
		chk(slip_comp_o, LOAD >>> 3);
		wr(`VFC_OFS_OPT, 32'hA);
		tick(2);
		chk(slip_comp_o, 32'h0);
		@(posedge clk_i) regen_i <= 1'b0;
		wr(`VFC_OFS_CTRL, 32'h0);
		tick(2);
		chk(slip_comp_o, 32'h0);
		wr(`VFC_OFS_CURF, 32'h0);
		tick(2);
		chk({cur_total_flt_o, cur_active_flt_o}, {LOAD, LOAD >>> 1});
		wr(`VFC_OFS_CURF, 32'h4);
		tick(10);
		wb(1'b0, `VFC_OFS_STAT, 32'h0);
		chk(rdata[4], 1'b0);
		tick(4);
		wb(1'b0, `VFC_OFS_STAT, 32'h0);
		chk(rdata[4], 1'b1);
		@(posedge clk_i) pulse_fb_fault_raw_i <= 1'b1;
		@(posedge clk_i) switch_overtemp_alarm_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk({deadtime_corr_o, pulse_feedback_fault_o, ot_reduce_o, ot_trip_o}, {16'h0006, 3'b110});
		wr(`VFC_OFS_OPT, 32'h4);
		chk({deadtime_corr_o, pulse_feedback_fault_o, ot_reduce_o, ot_trip_o}, {16'h0000, 3'b001});
		@(posedge clk_i) load <= LOAD + 16'sh0040;
		repeat (2) @(posedge clk_i);
		chk(stab_corr_o[15], 1'b1);
		wr(`VFC_OFS_OPT, 32'h0);
		chk(stab_corr_o, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(SAT_ADR[i], 32'hFFFF);
			rd(SAT_ADR[i], SAT_EXP[i]);
		end
		summarize();
	end
endmodule : tb_top
`default_nettype wire

// ===== verification/vfc_stage_model.sv
// Purpose: Behavioural power stage and motor seen by the block.
// Assumes: Currents follow the bench load while pulses run.
// Notes: Dead time shortens every measured pulse by DEAD_TIME while pulses run.
`timescale 1ns/1ps
`default_nettype none
module vfc_stage_model #(
	parameter logic [15:0] DEAD_TIME = 16'h0006
) (
	// Drive and bench settings
	input wire vfc_pkg::vfc_drive_t drive_i,
	input wire logic signed [15:0] load_i,
	input wire logic [15:0] pulse_cmd_i,
	// Measurements
	output logic signed [15:0] cur_total_o,
	output logic signed [15:0] cur_active_o,
	output logic signed [15:0] slip_o,
	output logic [15:0] pulse_meas_o
);
	import vfc_pkg::*;
	// A stopped stage carries no current; its pulse feedback is not held but inverted so nothing stale looks valid.
	always_comb begin
		cur_total_o = drive_i.pwm_en ? load_i : 16'sh0000;
		cur_active_o = cur_total_o >>> 1;
		slip_o = cur_total_o >>> 3;
		pulse_meas_o = drive_i.pwm_en ? pulse_cmd_i - DEAD_TIME : ~pulse_cmd_i;
	end
endmodule : vfc_stage_model
`default_nettype wire

// ===== verification/vfc_top_asserts.sv
// Purpose: Port-level checks of the V/f curve control block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to vfc_top at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module vfc_top_asserts #(
	parameter int TICK_CYCLES = 10,
	parameter bit RATED_50HZ = 1'b0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire vfc_pkg::vfc_wb_req_t wb_req_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Stage side
	input wire logic dc_brake_i,
	input wire logic [15:0] pulse_cmd_i,
	input wire logic [15:0] pulse_meas_i,
	input wire logic pulse_fb_fault_raw_i,
	input wire logic switch_overtemp_alarm_i,
	input wire vfc_pkg::vfc_drive_t drive_o,
	input wire logic signed [15:0] deadtime_corr_o,
	input wire logic pulse_feedback_fault_o,
	input wire logic ot_reduce_o,
	input wire logic ot_trip_o,
	input wire logic sensorless_vector_mode_o,
	input wire logic guided_setup_menu_o
);
	import vfc_pkg::*;
	logic [1:0] up_cnt_reg;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ****
	// Checks
	// ****
	// Counts edges out of reset so that no $past value is taken from inside reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) up_cnt_reg <= 2'h0;
		else if (up_cnt_reg != 2'h3) up_cnt_reg <= up_cnt_reg + 2'h1;
	end
	sequence bus_taken; wb_req_i.cyc && wb_req_i.stb && !wb_ack_o; endsequence
	sequence ack_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
	chk_ack_timing: assert property (bus_taken |=> ack_pulse) else $error("ack late or too long");
	chk_read_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
	chk_pwm_cut: assert property (up_cnt_reg[1] && drive_o.freq == 16'h0 && !$past(dc_brake_i) |-> !drive_o.pwm_en)
		else $error("pulses at zero frequency");
	chk_brake_pulses: assert property (up_cnt_reg[1] && $past(dc_brake_i) |-> drive_o.pwm_en)
		else $error("pulses cut while braking");
	chk_volt_range: assert property (drive_o.volt <= 16'h03E8) else $error("voltage above full scale");
	chk_freq_range: assert property (drive_o.freq <= 16'h1388) else $error("frequency above range");
	chk_dt_value: assert property (deadtime_corr_o != 16'sh0 |->
		deadtime_corr_o == $signed(16'($past(pulse_cmd_i) - $past(pulse_meas_i)))) else $error("dead time term wrong");
	chk_fault_gate: assert property (pulse_feedback_fault_o |-> $past(pulse_fb_fault_raw_i))
		else $error("feedback fault without cause");
	chk_ot_action: assert property (up_cnt_reg[1] |->
		((ot_reduce_o || ot_trip_o) == $past(switch_overtemp_alarm_i)) && !(ot_reduce_o && ot_trip_o))
		else $error("overtemperature action wrong");
	chk_setup_vector: assert property ($rose(guided_setup_menu_o) |-> sensorless_vector_mode_o)
		else $error("setup menu without vector mode");
	chk_reset_scalar: assert property ($fell(rst_i) |-> !sensorless_vector_mode_o [*2])
		else $error("vector mode after reset");
endmodule : vfc_top_asserts
bind vfc_top vfc_top_asserts #(.TICK_CYCLES(TICK_CYCLES), .RATED_50HZ(RATED_50HZ)) vfc_top_asserts_inst (
	.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.dc_brake_i(dc_brake_i), .pulse_cmd_i(pulse_cmd_i), .pulse_meas_i(pulse_meas_i),
	.pulse_fb_fault_raw_i(pulse_fb_fault_raw_i), .switch_overtemp_alarm_i(switch_overtemp_alarm_i),
	.drive_o(drive_o), .deadtime_corr_o(deadtime_corr_o), .pulse_feedback_fault_o(pulse_feedback_fault_o),
	.ot_reduce_o(ot_reduce_o), .ot_trip_o(ot_trip_o), .sensorless_vector_mode_o(sensorless_vector_mode_o),
	.guided_setup_menu_o(guided_setup_menu_o)
);
`default_nettype wire
